// ### inc/pes_pkg.sv
// Package: constants and carriers for the event select and decode block
package pes_pkg;
	// Selection register fields
	localparam int SEL_CODE_LSB = 25;
	localparam int SEL_CODE_W = 6;
	localparam int SEL_MASK_LSB = 9;
	localparam int SEL_MASK_W = 16;
	localparam logic [31:0] SEL_WMASK = 32'h7fff_fe00;
	localparam logic [31:0] SEL_RESET = 32'h0000_0000;
	// Counter configuration fields
	localparam int CFG_SEL_LSB = 13;
	localparam int CFG_SEL_W = 3;
	localparam int CFG_EN_BIT = 12;
	localparam logic [31:0] CFG_WMASK = 32'h0000_f000;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// Event select codes
	localparam logic [5:0] CODE_UOPQ_WRITES = 6'h09;
	localparam logic [5:0] CODE_BR_MISPRED = 6'h05;
	localparam logic [5:0] CODE_BR_RETIRED = 6'h04;
	localparam logic [5:0] CODE_RES_STALL = 6'h01;
	localparam logic [5:0] CODE_WRITE_COMBINE = 6'h05;
	// Counter configuration select values
	localparam logic [2:0] CFG_UOPQ = 3'h0;
	localparam logic [2:0] CFG_BRANCH = 3'h2;
	localparam logic [2:0] CFG_ALLOC = 3'h1;
	localparam logic [2:0] CFG_WRITE_COMBINE = 3'h5;
	// Mask bit positions
	localparam int M_SRC_TRACE_BUILD = 0;
	localparam int M_SRC_TRACE_DELIVER = 1;
	localparam int M_SRC_ROM = 2;
	localparam int M_BR_COND = 1;
	localparam int M_BR_CALL = 2;
	localparam int M_BR_RETURN = 3;
	localparam int M_BR_INDIRECT = 4;
	localparam int M_STORE_BUFFERS_EXHAUSTED = 5;
	localparam int M_COMBINE_BUFFER_EVICT_ANY = 0;
	localparam int M_COMBINE_BUFFER_EVICT_NO_FREE = 1;
	// Selection register slots: unit * 2 + instance
	localparam int SLOT_UOPQ = 0;
	localparam int SLOT_BRANCH = 2;
	localparam int SLOT_ALLOC = 4;
	localparam int SLOT_DATA_ACCESS = 6;
	localparam int NUM_SEL = 8;
	// Counters served: 4 to 17
	localparam int FIRST_CNT = 4;
	localparam int NUM_CNT = 14;
	// Instance feeding each served counter, bit k is counter FIRST_CNT + k
	localparam logic [13:0] CNT_INSTANCE = 14'h2ccc;
	// Byte addresses
	localparam logic [11:0] ADR_SEL_BASE = 12'h000;
	localparam logic [11:0] ADR_CFG_BASE = 12'h080;
	localparam logic [11:0] ADR_CNT_BASE = 12'h100;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;

	typedef struct packed {
		logic uopq_valid;
		logic src_trace_build;
		logic src_trace_deliver;
		logic src_rom;
		logic br_retire;
		logic br_mispred;
		logic br_cond;
		logic br_call_direct;
		logic br_call_indirect;
		logic br_return;
		logic br_jump_indirect;
		logic store_buffers_exhausted;
		logic combine_evict;
		logic combine_evict_no_free;
	} pes_events_t;
endpackage

// ### rtl/pes_top.sv
// Event qualification, counter routing and register file for counters 4 to 17
`timescale 1ns/10ps
module pes_top #(
	parameter int CNT_W = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire pes_pkg::pes_events_t events_i
);
	initial begin
		if (CNT_W < 1 || CNT_W > 32) begin
			$error("CNT_W must lie between 1 and 32");
		end
	end

	logic ack_reg;
	logic [31:0] dat_reg;
	logic [31:0] sel_reg [pes_pkg::NUM_SEL];
	logic [31:0] cfg_reg [pes_pkg::NUM_CNT];
	logic [CNT_W-1:0] cnt_reg [pes_pkg::NUM_CNT];
	logic [pes_pkg::NUM_SEL-1:0] hit_reg;
	logic [pes_pkg::NUM_SEL-1:0] hit_next;
	logic [pes_pkg::NUM_CNT-1:0] inc;
	logic access;
	logic [31:0] rd_next;
	logic [31:0] wr_bytes;

	// Access taken once; ack drops the cycle after it was given
	assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr_bytes = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask,
			input logic [31:0] lanes, input logic [31:0] data);
		logic [31:0] m;
		m = wmask & lanes;
		merge = (old & ~m) | (data & m);
	endfunction

	// Event decode per selection slot
	genvar s;
	generate
		for (s = 0; s < pes_pkg::NUM_SEL; s++) begin : g_slot
			logic [5:0] code;
			logic [15:0] m;
			assign code = sel_reg[s][pes_pkg::SEL_CODE_LSB +: pes_pkg::SEL_CODE_W];
			assign m = sel_reg[s][pes_pkg::SEL_MASK_LSB +: pes_pkg::SEL_MASK_W];
			if (s / 2 == pes_pkg::SLOT_UOPQ / 2) begin : g_uopq
				// One uop per cycle; matching any set source bit counts it once
				assign hit_next[s] = (code == pes_pkg::CODE_UOPQ_WRITES) & events_i.uopq_valid &
					((m[pes_pkg::M_SRC_TRACE_BUILD] & events_i.src_trace_build) |
					(m[pes_pkg::M_SRC_TRACE_DELIVER] & events_i.src_trace_deliver) |
					(m[pes_pkg::M_SRC_ROM] & events_i.src_rom));
			end else if (s / 2 == pes_pkg::SLOT_BRANCH / 2) begin : g_branch
				logic ind_any;
				logic type_mis;
				logic type_all;
				assign ind_any = events_i.br_return | events_i.br_call_indirect |
					events_i.br_jump_indirect;
				// Conditional counts follow retire reports as given, so replays
				// during trace rebuilds or pipeline clears inflate them
				assign type_mis = (m[pes_pkg::M_BR_COND] & events_i.br_cond) |
					(m[pes_pkg::M_BR_CALL] & events_i.br_call_indirect) |
					(m[pes_pkg::M_BR_RETURN] & events_i.br_return) |
					(m[pes_pkg::M_BR_INDIRECT] & ind_any);
				assign type_all = (m[pes_pkg::M_BR_COND] & events_i.br_cond) |
					(m[pes_pkg::M_BR_CALL] & (events_i.br_call_direct | events_i.br_call_indirect)) |
					(m[pes_pkg::M_BR_RETURN] & events_i.br_return) |
					(m[pes_pkg::M_BR_INDIRECT] & ind_any);
				assign hit_next[s] = events_i.br_retire &
					(((code == pes_pkg::CODE_BR_MISPRED) & events_i.br_mispred & type_mis) |
					((code == pes_pkg::CODE_BR_RETIRED) & type_all));
			end else if (s / 2 == pes_pkg::SLOT_ALLOC / 2) begin : g_alloc
				// Counts every stalled cycle, which gives latency; occurrences need edge
				assign hit_next[s] = (code == pes_pkg::CODE_RES_STALL) &
					m[pes_pkg::M_STORE_BUFFERS_EXHAUSTED] & events_i.store_buffers_exhausted;
			end else begin : g_combine
				assign hit_next[s] = (code == pes_pkg::CODE_WRITE_COMBINE) &
					events_i.combine_evict &
					(m[pes_pkg::M_COMBINE_BUFFER_EVICT_ANY] |
					(m[pes_pkg::M_COMBINE_BUFFER_EVICT_NO_FREE] & events_i.combine_evict_no_free));
			end
		end
	endgenerate

	// One register stage keeps the wide decode off the counter adders
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hit_reg <= '0;
		end else begin
			hit_reg <= hit_next;
		end
	end

	// Routing of slots onto served counters
	genvar k;
	generate
		for (k = 0; k < pes_pkg::NUM_CNT; k++) begin : g_cnt
			localparam int INST = pes_pkg::CNT_INSTANCE[k] ? 1 : 0;
			logic [2:0] csel;
			logic en;
			assign csel = cfg_reg[k][pes_pkg::CFG_SEL_LSB +: pes_pkg::CFG_SEL_W];
			assign en = cfg_reg[k][pes_pkg::CFG_EN_BIT];
			if (k < 4) begin : g_front
				// Counters 4 to 7 share the uop queue and branch selections
				assign inc[k] = en & (((csel == pes_pkg::CFG_UOPQ) & hit_reg[pes_pkg::SLOT_UOPQ + INST]) |
					((csel == pes_pkg::CFG_BRANCH) & hit_reg[pes_pkg::SLOT_BRANCH + INST]));
			end else if (k < 8) begin : g_dac
				assign inc[k] = en & (csel == pes_pkg::CFG_WRITE_COMBINE) &
					hit_reg[pes_pkg::SLOT_DATA_ACCESS + INST];
			end else begin : g_alf
				assign inc[k] = en & (csel == pes_pkg::CFG_ALLOC) &
					hit_reg[pes_pkg::SLOT_ALLOC + INST];
			end

			logic hit_adr;
			assign hit_adr = wb_adr_i == 12'(pes_pkg::ADR_CNT_BASE + 12'(4 * k));
			// Software write wins over a count in the same cycle
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					cnt_reg[k] <= CNT_W'(pes_pkg::CNT_RESET);
				end else if (access & wb_we_i & hit_adr) begin
					cnt_reg[k] <= CNT_W'(merge(32'(cnt_reg[k]), 32'hffff_ffff, wr_bytes, wb_dat_i));
				end else if (inc[k]) begin
					cnt_reg[k] <= cnt_reg[k] + CNT_W'(1);
				end
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					cfg_reg[k] <= pes_pkg::CFG_RESET;
				end else if (access & wb_we_i &
						(wb_adr_i == 12'(pes_pkg::ADR_CFG_BASE + 12'(4 * k)))) begin
					cfg_reg[k] <= merge(cfg_reg[k], pes_pkg::CFG_WMASK, wr_bytes, wb_dat_i);
				end
			end
		end

		for (s = 0; s < pes_pkg::NUM_SEL; s++) begin : g_selreg
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					sel_reg[s] <= pes_pkg::SEL_RESET;
				end else if (access & wb_we_i &
						(wb_adr_i == 12'(pes_pkg::ADR_SEL_BASE + 12'(4 * s)))) begin
					sel_reg[s] <= merge(sel_reg[s], pes_pkg::SEL_WMASK, wr_bytes, wb_dat_i);
				end
			end
		end
	endgenerate

	// Read decode; unmapped addresses read zero and are still acknowledged
	always_comb begin
		rd_next = 32'h0000_0000;
		for (int i = 0; i < pes_pkg::NUM_SEL; i++) begin
			if (wb_adr_i == 12'(pes_pkg::ADR_SEL_BASE + 12'(4 * i))) begin
				rd_next = sel_reg[i];
			end
		end
		for (int i = 0; i < pes_pkg::NUM_CNT; i++) begin
			if (wb_adr_i == 12'(pes_pkg::ADR_CFG_BASE + 12'(4 * i))) begin
				rd_next = cfg_reg[i];
			end else if (wb_adr_i == 12'(pes_pkg::ADR_CNT_BASE + 12'(4 * i))) begin
				rd_next = 32'(cnt_reg[i]);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= access;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dat_reg <= 32'h0000_0000;
		end else if (access & ~wb_we_i) begin
			dat_reg <= rd_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
endmodule // pes_top

// ### bench/pes_checker.sv
// Checker: port-level assertions for the event decode block
`timescale 1ns/10ps
module pes_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire pes_pkg::pes_events_t events_i
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence taken_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence rd_ack_s;
		wb_ack_o && !wb_we_i;
	endsequence
	ack_latency_a: assert property (taken_s |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	read_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
		else $error("read data moved");
	unmapped_read_a: assert property (rd_ack_s ##0 (wb_adr_i >= 12'h138) |-> wb_dat_o == '0)
		else $error("unmapped read not zero");
	misaligned_read_a: assert property (rd_ack_s ##0 (wb_adr_i[1:0] != 2'h0) |-> wb_dat_o == '0)
		else $error("misaligned read not zero");
	select_fields_a: assert property (rd_ack_s ##0 (wb_adr_i < 12'h020)
		|-> (wb_dat_o & ~pes_pkg::SEL_WMASK) == '0) else $error("select spare bits set");
	config_fields_a: assert property (rd_ack_s ##0 (wb_adr_i >= 12'h080 && wb_adr_i < 12'h0b8)
		|-> (wb_dat_o & ~pes_pkg::CFG_WMASK) == '0) else $error("config spare bits set");
endmodule // pes_checker
bind pes_top pes_checker chk_i (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .events_i(events_i));

// ### bench/pes_partner.sv
// Partner: pipeline units reporting one event kind per cycle
`timescale 1ns/10ps
module pes_partner (
	input wire logic clk,
	input wire logic reset,
	input wire logic fire,
	input wire logic [3:0] kind,
	output pes_pkg::pes_events_t ev
);
	// Kinds: uop build, deliver, rom; cond, return, mispred ind call,
	// mispred direct call, ind call; evict, evict no free, store stall
	localparam logic [13:0] PAT [0:10] = '{14'h3000, 14'h2800, 14'h2400, 14'h0280,
		14'h0210, 14'h0320, 14'h0340, 14'h0220, 14'h0002, 14'h0003, 14'h0004};
	// Idle cycles report nothing, so no stale flag can be counted
	always_ff @(posedge clk or posedge reset) begin
		if (reset || !fire) begin
			ev <= '0;
		end else begin
			ev <= pes_pkg::pes_events_t'(PAT[kind]);
		end
	end
endmodule // pes_partner

// ### bench/tb_top.sv
// Testbench: register access and event counting scenarios
`timescale 1ns/10ps
module tb_top;
	logic clk, reset, cyc, stb, we, ack, fire;
	logic [11:0] adr;
	logic [31:0] dat, dato, q;
	logic [3:0] kind;
	logic [3:0] sel;
	pes_pkg::pes_events_t ev;
	int mismatches = 0;
	int compares = 0;
	pes_top dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
		.events_i(ev));
	pes_partner unit (.clk(clk), .reset(reset), .fire(fire), .kind(kind), .ev(ev));
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dato;
		{cyc, stb} <= 2'b00;
		chk("ack", 32'h0000_0001, {31'h0, ack});
	endtask
	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask
	task automatic arm(input int s, input logic [31:0] v, input int n, input logic [31:0] c);
		wb(1'b1, 12'(s * 4), v);
		wb(1'b1, 12'h080 + 12'((n - 4) * 4), c);
	endtask
	// Counter lags the report by two edges, so three idle edges suffice
	task automatic send(input logic [3:0] k, input int cnt);
		@(posedge clk);
		kind <= k;
		fire <= 1'b1;
		repeat (cnt) @(posedge clk);
		fire <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_reset;
		rc("select", 12'h004, pes_pkg::SEL_RESET);
		rc("config", 12'h080, pes_pkg::CFG_RESET);
		rc("count", 12'h100, pes_pkg::CNT_RESET);
		wb(1'b1, 12'h200, 32'hffff_ffff);
		rc("unmapped", 12'h200, 32'h0000_0000);
		rc("misaligned", 12'h006, 32'h0000_0000);
		wb(1'b1, 12'h004, 32'hffff_ffff);
		rc("select bits", 12'h004, pes_pkg::SEL_WMASK);
		wb(1'b1, 12'h08c, 32'hffff_ffff);
		rc("config bits", 12'h08c, pes_pkg::CFG_WMASK);
		// Byte lanes: only the two low bytes may land
		sel <= 4'h3;
		wb(1'b1, 12'h100, 32'h1234_5678);
		sel <= 4'hf;
		rc("count bytes", 12'h100, 32'h0000_5678);
		wb(1'b1, 12'h100, 32'h0000_0000);
		rc("count cleared", 12'h100, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_branch;
		arm(2, 32'h0800_0c00, 4, 32'h0000_5000);
		arm(3, 32'h0000_0000, 6, 32'h0000_5000);
		send(4'h3, 4);
		send(4'h6, 2);
		send(4'h4, 3);
		rc("branch cnt4", 12'h100, 32'h0000_0006);
		rc("branch cnt6", 12'h108, 32'h0000_0000);
		$display("test branch done");
	endtask
	task automatic t_mispred;
		arm(3, 32'h0a00_0800, 6, 32'h0000_5000);
		send(4'h5, 3);
		send(4'h6, 2);
		send(4'h7, 2);
		rc("mispred cnt6", 12'h108, 32'h0000_0003);
		$display("test mispredict done");
	endtask
	task automatic t_combine;
		arm(6, 32'h0a00_0600, 8, 32'h0000_b000);
		arm(7, 32'h0a00_0400, 10, 32'h0000_b000);
		send(4'h8, 3);
		send(4'h9, 2);
		rc("combine cnt8", 12'h110, 32'h0000_0005);
		rc("combine cnt10", 12'h118, 32'h0000_0002);
		$display("test combine done");
	endtask
	task automatic t_stall;
		arm(5, 32'h0200_4000, 14, 32'h0000_3000);
		arm(4, 32'h0000_0000, 12, 32'h0000_3000);
		send(4'ha, 5);
		rc("stall cnt14", 12'h128, 32'h0000_0005);
		rc("stall cnt12", 12'h120, 32'h0000_0000);
		$display("test stall done");
	endtask
	task automatic t_uopq;
		arm(0, 32'h1200_0a00, 5, 32'h0000_1000);
		send(4'h0, 2);
		send(4'h1, 3);
		send(4'h2, 4);
		rc("uop cnt5", 12'h104, 32'h0000_0006);
		$display("test uop queue done");
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		close_out;
	end
	initial begin
		{reset, cyc, stb, we, fire, kind, adr, dat} = {5'b10000, 4'h0, 12'h000, 32'h0000_0000};
		sel = 4'hf;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_branch;
		t_mispred;
		t_combine;
		t_stall;
		t_uopq;
		close_out;
	end
endmodule // tb_top
